/* File: core/led_drive_core.sv */
// led_drive_core: serial-loaded five-bank multiplexed led driver logic.
// assumes: serial clock on SCLK_I from the host, idle low; LINK_EN_N_I
// only changes while SCLK_I is low; anode and bank outputs feed drivers.
//
// Overview of operation
// - low-power mode stops the scan and darkens the anode and bank outputs while registers and the port keep working.
// - hex mode shows 0 to 9 and A, b, C, d, E, F for nibble values 0 to 15.
// - special mode shows blank, then C H h J L n o P r U u y dash equals degree.
// - no-decode mode drives a to d straight from the nibble bits and holds e, f, g low.
// - the decimal output h follows its own control the same way in every mode.
// - the three h control bits can light the h lamps of banks 1 and 2 together.
// - data goes msb first, sampled on the rising serial edge and passed on at the falling edge.
// - enable high stops shifting, resets the port, drives data-out low, and its rise loads a register.
// - a lone device takes 8 clocks for config and 24 for display, and the display waits for enable.
`timescale 1ns/1ps
`default_nettype none
module led_drive_core #(
  parameter int unsigned BANK_SLOT = led_pkg::BANK_SLOT_CYCLES
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       RSTN_I,
  input  wire logic       SCLK_I,
  input  wire logic       LINK_EN_N_I,
  input  wire logic       DIN_I,
  output logic            DOUT_O,
  output logic [7:0]      ANODE_O,
  output logic [4:0]      BANK_O,
  output logic            BRIGHT_O,
  output logic            LOW_POWER_O
);

  // ----------------------------------------------------------------
  // link domain: shift chain
  // ----------------------------------------------------------------
  logic [23:0] shreg_r;
  logic [23:0] shreg_nxt;
  logic [6:0]  cnt_r;
  logic [6:0]  cnt_nxt;
  logic        fresh_r;
  logic        dout_r;
  wire         chain_bit = shreg_r[led_pkg::SHIFT_W - 1];

  assign shreg_nxt = LINK_EN_N_I ? shreg_r : {shreg_r[22:0], DIN_I};
  assign cnt_nxt   = LINK_EN_N_I ? cnt_r :
                     fresh_r ? led_pkg::CNT_ONE :
                     (cnt_r == led_pkg::CNT_MAX) ? cnt_r : cnt_r + led_pkg::CNT_ONE;

  always_ff @(posedge SCLK_I) begin
    shreg_r <= shreg_nxt;
    cnt_r   <= cnt_nxt;
  end

  always_ff @(posedge SCLK_I or posedge LINK_EN_N_I) begin
    if (LINK_EN_N_I) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  always_ff @(negedge SCLK_I or posedge LINK_EN_N_I) begin
    if (LINK_EN_N_I) begin
      dout_r <= 1'b0;
    end else begin
      dout_r <= chain_bit;
    end
  end

  assign DOUT_O = dout_r;

  // ----------------------------------------------------------------
  // link word crossing into the core domain
  // ----------------------------------------------------------------
  logic [23:0] shreg_s1_r;
  logic [23:0] shreg_s2_r;
  logic [6:0]  cnt_s1_r;
  logic [6:0]  cnt_s2_r;

  always_ff @(posedge CORE_CLK_I) begin
    shreg_s1_r <= shreg_r;
    shreg_s2_r <= shreg_s1_r;
    cnt_s1_r   <= cnt_r;
    cnt_s2_r   <= cnt_s1_r;
  end

  // ----------------------------------------------------------------
  // core domain: enable edge and register load
  // ----------------------------------------------------------------
  logic        en_s1_r;
  logic        en_s2_r;
  logic        en_d_r;
  logic [7:0]  cfg_r;
  logic [7:0]  cfg_nxt;
  logic [23:0] disp_r;
  logic [23:0] disp_nxt;
  wire         en_rise  = en_s2_r & ~en_d_r;
  wire [2:0]   cnt_tail = cnt_s2_r[led_pkg::CNT_BYTE_LO - 1:0];
  wire         cnt_none = (cnt_s2_r == '0);
  wire         len_ok   = (cnt_tail == '0) && !cnt_none;
  wire         is_disp  = cnt_s2_r[led_pkg::CNT_KIND_BIT];
  wire         load_cfg  = en_rise & len_ok & ~is_disp;
  wire         load_disp = en_rise & len_ok & is_disp;

  assign cfg_nxt  = load_cfg  ? shreg_s2_r[led_pkg::CFG_W - 1:0] : cfg_r;
  assign disp_nxt = load_disp ? shreg_s2_r : disp_r;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      en_s1_r <= 1'b1;
      en_s2_r <= 1'b1;
      en_d_r  <= 1'b1;
      cfg_r   <= led_pkg::CFG_RST;
      disp_r  <= led_pkg::DISP_RST;
    end else begin
      en_s1_r <= LINK_EN_N_I;
      en_s2_r <= en_s1_r;
      en_d_r  <= en_s2_r;
      cfg_r   <= cfg_nxt;
      disp_r  <= disp_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bank scan
  // ----------------------------------------------------------------
  logic [15:0] slot_r;
  logic [15:0] slot_nxt;
  logic [2:0]  bank_r;
  logic [2:0]  bank_nxt;
  wire         low_power = ~cfg_r[led_pkg::CFG_RUN_BIT];
  wire         slot_end  = (slot_r == 16'(BANK_SLOT - 1));
  wire         bank_last = (bank_r == 3'(led_pkg::BANKS - 1));

  assign slot_nxt = low_power ? 16'h0000 : slot_end ? 16'h0000 : slot_r + 16'h0001;
  assign bank_nxt = low_power ? 3'h0 :
                    !slot_end ? bank_r :
                    bank_last ? 3'h0 : bank_r + 3'h1;

  // ----------------------------------------------------------------
  // per-bank mode, nibble and h lamp
  // ----------------------------------------------------------------
  led_pkg::dec_mode_t mode_arr [led_pkg::BANKS];
  logic [3:0]         nib_arr  [led_pkg::BANKS];
  logic [4:0]         h_vec;
  wire  [2:0]         h_code = disp_r[led_pkg::LAMP_H_LSB +: 3];

  genvar gi;
  generate
    for (gi = 0; gi < led_pkg::BANKS; gi++) begin : g_bank
      wire spec = (gi < led_pkg::SPEC_LOW_BANKS) ? cfg_r[led_pkg::CFG_SPEC_LOW]
                                                  : cfg_r[led_pkg::CFG_SPEC_HIGH];
      assign mode_arr[gi] = cfg_r[led_pkg::CFG_NODEC_LSB + gi] ? led_pkg::MODE_NODEC :
                            spec ? led_pkg::MODE_SPECIAL : led_pkg::MODE_HEX;
      assign nib_arr[gi]  = disp_r[gi * led_pkg::NIB_W +: led_pkg::NIB_W];
      wire h_own  = (h_code == 3'(gi + 1));
      wire h_pair = (h_code == led_pkg::H_PAIR) && (gi < 2);
      assign h_vec[gi] = h_own || (h_code == led_pkg::H_ALL) || h_pair;
    end
  endgenerate

  // ----------------------------------------------------------------
  // decode of the active bank
  // ----------------------------------------------------------------
  logic [7:0] anode_dec;
  logic [7:0] anode_nxt;
  logic [4:0] bank_on_nxt;

  // active bank decoded in its mode
  seg_decode u_dec (
    .nib_i   (nib_arr[bank_r]),
    .mode_i  (mode_arr[bank_r]),
    .h_i     (h_vec[bank_r]),
    .anode_o (anode_dec)
  );

  assign anode_nxt   = low_power ? 8'h00 : anode_dec;
  wire [4:0] bank_onehot = 5'(5'h01 << bank_r);
  assign bank_on_nxt = low_power ? 5'h00 : bank_onehot;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RSTN_I) begin
      slot_r      <= 16'h0000;
      bank_r      <= 3'h0;
      ANODE_O     <= 8'h00;
      BANK_O      <= 5'h00;
      BRIGHT_O    <= 1'b0;
      LOW_POWER_O <= 1'b1;
    end else begin
      slot_r      <= slot_nxt;
      bank_r      <= bank_nxt;
      ANODE_O     <= anode_nxt;
      BANK_O      <= bank_on_nxt;
      BRIGHT_O    <= disp_r[led_pkg::BRIGHT_BIT];
      LOW_POWER_O <= low_power;
    end
  end

endmodule : led_drive_core
`default_nettype wire

/* File: core/led_pkg.sv */
// led_pkg: shared constants for the multiplexed led driver core.
// assumes: 100 MHz core clock, independent serial link clock.
package led_pkg;

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  localparam int unsigned SHIFT_W     = 24;
  localparam int unsigned CNT_W       = 7;
  localparam logic [6:0]  CNT_MAX     = 7'h7F;
  localparam logic [6:0]  CNT_ONE     = 7'h01;
  localparam int unsigned CNT_BYTE_LO = 3;
  localparam int unsigned CNT_KIND_BIT = 4;
  localparam int unsigned CFG_W       = 8;

  // ----------------------------------------------------------------
  // configuration register fields
  // ----------------------------------------------------------------
  localparam int unsigned CFG_RUN_BIT   = 0;
  localparam int unsigned CFG_NODEC_LSB = 1;
  localparam int unsigned CFG_SPEC_LOW  = 6;
  localparam int unsigned CFG_SPEC_HIGH = 7;
  localparam int unsigned SPEC_LOW_BANKS = 3;
  localparam logic [7:0]  CFG_RST       = 8'h00;

  // ----------------------------------------------------------------
  // display register fields
  // ----------------------------------------------------------------
  localparam int unsigned NIB_W       = 4;
  localparam int unsigned LAMP_H_LSB  = 20;
  localparam int unsigned BRIGHT_BIT  = 23;
  localparam logic [23:0] DISP_RST    = 24'h00_0000;
  localparam logic [2:0]  H_NONE      = 3'h0;
  localparam logic [2:0]  H_ALL       = 3'h6;
  localparam logic [2:0]  H_PAIR      = 3'h7;

  // ----------------------------------------------------------------
  // scan timing
  // ----------------------------------------------------------------
  localparam int unsigned BANKS        = 5;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned BANK_SLOT_NS = 200_000;
  localparam int unsigned BANK_SLOT_CYCLES = BANK_SLOT_NS / CLK_PERIOD_NS;
  localparam int unsigned SLOT_W       = 16;

  typedef enum logic [1:0] {
    MODE_HEX     = 2'b00,
    MODE_SPECIAL = 2'b01,
    MODE_NODEC   = 2'b10
  } dec_mode_t;

endpackage : led_pkg

/* File: core/seg_decode.sv */
// seg_decode: nibble to anode pattern for one bank slot.
// assumes: caller registers the result; bit 0 is anode a, bit 7 is h.
`timescale 1ns/1ps
`default_nettype none
module seg_decode (
  input  wire logic [3:0]       nib_i,
  input  wire led_pkg::dec_mode_t mode_i,
  input  wire logic             h_i,
  output logic [7:0]            anode_o
);

  logic [6:0] hex_seg;
  logic [6:0] spec_seg;
  logic [6:0] nodec_seg;
  logic [6:0] seg_sel;

  // ----------------------------------------------------------------
  // hex characters
  // ----------------------------------------------------------------
  // hex glyph table
  always_comb begin
    case (nib_i)
      4'h0: hex_seg = 7'h3F;
      4'h1: hex_seg = 7'h06;
      4'h2: hex_seg = 7'h5B;
      4'h3: hex_seg = 7'h4F;
      4'h4: hex_seg = 7'h66;
      4'h5: hex_seg = 7'h6D;
      4'h6: hex_seg = 7'h7D;
      4'h7: hex_seg = 7'h07;
      4'h8: hex_seg = 7'h7F;
      4'h9: hex_seg = 7'h6F;
      4'hA: hex_seg = 7'h77;
      4'hB: hex_seg = 7'h7C;
      4'hC: hex_seg = 7'h39;
      4'hD: hex_seg = 7'h5E;
      4'hE: hex_seg = 7'h79;
      default: hex_seg = 7'h71;
    endcase
  end

  // ----------------------------------------------------------------
  // special symbols
  // ----------------------------------------------------------------
  // symbol glyph table
  always_comb begin
    case (nib_i)
      4'h0: spec_seg = 7'h00;
      4'h1: spec_seg = 7'h39;
      4'h2: spec_seg = 7'h76;
      4'h3: spec_seg = 7'h74;
      4'h4: spec_seg = 7'h1E;
      4'h5: spec_seg = 7'h38;
      4'h6: spec_seg = 7'h54;
      4'h7: spec_seg = 7'h5C;
      4'h8: spec_seg = 7'h73;
      4'h9: spec_seg = 7'h50;
      4'hA: spec_seg = 7'h3E;
      4'hB: spec_seg = 7'h1C;
      4'hC: spec_seg = 7'h6E;
      4'hD: spec_seg = 7'h40;
      4'hE: spec_seg = 7'h48;
      default: spec_seg = 7'h63;
    endcase
  end

  assign nodec_seg = {3'h0, nib_i};

  assign seg_sel = (mode_i == led_pkg::MODE_NODEC)   ? nodec_seg :
                   (mode_i == led_pkg::MODE_SPECIAL) ? spec_seg  : hex_seg;

  assign anode_o = {h_i, seg_sel};

endmodule : seg_decode
`default_nettype wire

/* File: dv/led_chk.sv */
// led_chk: port checks for the led driver core
// assumes: bound into every led_drive_core
`timescale 1ns/1ps
`default_nettype none
module led_chk #(
  parameter int unsigned BANK_SLOT = 8
) (
  input wire logic       CORE_CLK_I,
  input wire logic       RSTN_I,
  input wire logic       SCLK_I,
  input wire logic       LINK_EN_N_I,
  input wire logic       DIN_I,
  input wire logic       DOUT_O,
  input wire logic [7:0] ANODE_O,
  input wire logic [4:0] BANK_O,
  input wire logic       BRIGHT_O,
  input wire logic       LOW_POWER_O
);
  // ----------------------------------------
  // helpers and checks
  // ----------------------------------------
  logic [4:0]  bank_q_r;
  logic [15:0] slot_r;
  logic [2:0]  since_r;
  logic        en_q_r;
  logic [23:0] hist_r;
  logic [4:0]  bits_r;
  always_ff @(posedge CORE_CLK_I) begin
    bank_q_r <= BANK_O;
    slot_r   <= (BANK_O != bank_q_r) ? 16'h0001 : slot_r + 16'h0001;
    en_q_r   <= LINK_EN_N_I;
    since_r  <= !RSTN_I ? 3'h7 : (LINK_EN_N_I && !en_q_r) ? 3'h0 : (since_r == 3'h7) ? 3'h7 : since_r + 3'h1;
  end
  always_ff @(posedge SCLK_I or posedge LINK_EN_N_I) begin
    if (LINK_EN_N_I) begin
      bits_r <= 5'h00;
    end else begin
      hist_r <= {hist_r[22:0], DIN_I};
      bits_r <= (bits_r == 5'h1F) ? 5'h1F : bits_r + 5'h01;
    end
  end
  a_reset_dark: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    $past(RSTN_I) == 1'b0 |-> LOW_POWER_O && BANK_O == 5'h00 && ANODE_O == 8'h00 && !BRIGHT_O)
    else $error("outputs not dark after reset");
  a_lp_dark: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    LOW_POWER_O && $past(LOW_POWER_O) |-> BANK_O == 5'h00 && ANODE_O == 8'h00)
    else $error("outputs lit in low power");
  a_scan_start: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    $fell(LOW_POWER_O) |-> BANK_O == 5'h01)
    else $error("scan does not start at bank one");
  a_bank_rotate: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    BANK_O != bank_q_r && BANK_O != 5'h00 && bank_q_r != 5'h00 |-> BANK_O == {bank_q_r[3:0], bank_q_r[4]})
    else $error("bank order broken");
  a_slot_len: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    BANK_O != bank_q_r && BANK_O != 5'h00 && bank_q_r != 5'h00 |-> slot_r == BANK_SLOT)
    else $error("bank slot length wrong");
  a_dout_idle: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    LINK_EN_N_I && $past(LINK_EN_N_I) |-> !DOUT_O)
    else $error("data out not low while disabled");
  a_dout_chain: assert property (@(posedge SCLK_I) disable iff (LINK_EN_N_I)
    bits_r >= 5'h18 |-> DOUT_O == hist_r[23])
    else $error("data out not delayed by 24 bits");
  a_load_time: assert property (@(posedge CORE_CLK_I) disable iff (!RSTN_I)
    $changed(BRIGHT_O) || $changed(LOW_POWER_O) |-> since_r <= 3'h4)
    else $error("register changed away from enable rise");
endmodule : led_chk
bind led_drive_core led_chk #(.BANK_SLOT(BANK_SLOT)) led_chk_inst (.CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I),
  .SCLK_I(SCLK_I), .LINK_EN_N_I(LINK_EN_N_I), .DIN_I(DIN_I), .DOUT_O(DOUT_O), .ANODE_O(ANODE_O),
  .BANK_O(BANK_O), .BRIGHT_O(BRIGHT_O), .LOW_POWER_O(LOW_POWER_O));
`default_nettype wire

/* File: dv/host_port_model.sv */
// host_port_model: serial host on the link pins
// assumes: 125 ns link clock, idle low between frames
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
  output logic      sclk_o,
  output logic      en_n_o,
  output logic      din_o,
  input  wire logic dout_i
);
  // ----------------------------------------
  // frame driver
  // ----------------------------------------
  logic [127:0] cap;
  // enable rises after time zero so the port preset is seen
  initial begin
    sclk_o = 1'b0;
    din_o  = 1'b0;
    #1;
    en_n_o = 1'b1;
  end
  task automatic send(input logic [127:0] bits, input int n);
    en_n_o = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din_o = bits[i];
      #62.5;
      cap = {cap[126:0], dout_i};
      sclk_o = 1'b1;
      #62.5;
      sclk_o = 1'b0;
    end
    #62.5;
    en_n_o = 1'b1;
    din_o = ~din_o;
    #250;
  endtask : send
endmodule : host_port_model
`default_nettype wire

/* File: dv/tb_top.sv */
// tb_top: self-checking bench for led_drive_core
// assumes: host model drives the link, short bank slot
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ----------------------------------------
  // bench
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] bank;
    logic [7:0] anode;
    logic       lp;
    logic       bright;
  } note_t;
  logic        clk, rstn, sclk, en_n, din, dout, bright, lp;
  logic [7:0]  anode;
  logic [4:0]  bank;
  int          errors, num_checks;
  logic [31:0] seed = 32'h0000_025C;
  logic [7:0]  cfg = 8'h00;
  logic [23:0] disp = 24'h00_0000;
  note_t       notes[$];
  note_t       nt;
  int          disp_len [5] = '{24, 48, 80, 112, 120};
  logic [6:0]  hex_seg [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
                                 7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
  logic [6:0]  spc_seg [16] = '{7'h00, 7'h39, 7'h76, 7'h74, 7'h1E, 7'h38, 7'h54, 7'h5C,
                                 7'h73, 7'h50, 7'h3E, 7'h1C, 7'h6E, 7'h40, 7'h48, 7'h63};
  led_drive_core #(.BANK_SLOT(8)) led_drive_core_inst (.CORE_CLK_I(clk), .RSTN_I(rstn), .SCLK_I(sclk),
    .LINK_EN_N_I(en_n), .DIN_I(din), .DOUT_O(dout), .ANODE_O(anode), .BANK_O(bank),
    .BRIGHT_O(bright), .LOW_POWER_O(lp));
  host_port_model host_port_model_inst (.sclk_o(sclk), .en_n_o(en_n), .din_o(din), .dout_i(dout));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [7:0] seg(int k);
    logic [3:0] nb;
    logic [2:0] hc;
    logic       h;
    nb = disp[4*k +: 4];
    hc = disp[22:20];
    h = (hc == 3'h6) || (hc == k + 1) || (hc == 3'h7 && k < 2);
    if (cfg[1 + k]) return {h, 3'h0, nb};
    if (k < 3 ? cfg[6] : cfg[7]) return {h, spc_seg[nb]};
    return {h, hex_seg[nb]};
  endfunction : seg
  task automatic stop_test();
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic expect_scan();
    int t;
    for (int k = 0; k < 5; k++)
      notes.push_back(cfg[0] ? note_t'{5'h01 << k, seg(k), 1'b0, disp[23]} : note_t'{5'h00, 8'h00, 1'b1, disp[23]});
    for (t = 0; t < 400 && notes.size() > 0; t++) @(posedge clk);
    if (notes.size() > 0) begin
      errors++;
      $display("[ERR] %0t scan result missing", $time);
      stop_test();
    end
  endtask : expect_scan
  // frame of n bits, payload in low w bits
  task automatic load(input logic [23:0] val, input int n, input int w);
    logic [127:0] bits;
    logic [127:0] msk;
    bits = {rnd(), rnd(), rnd(), rnd()};
    msk = (128'h1 << w) - 128'h1;
    bits = (bits & ~msk) | ({104'h0, val} & msk);
    @(posedge clk);
    #1;
    host_port_model_inst.send(bits, n);
    msk = (128'h1 << (n - 24)) - 128'h1;
    if (n > 24) begin
      num_checks++;
      if (((host_port_model_inst.cap ^ (bits >> 24)) & msk) !== 128'h0) begin
        errors++;
        $display("[ERR] %0t chain output wrong", $time);
      end
    end
    repeat (12) @(posedge clk);
  endtask : load
  always @(posedge clk) begin
    if (notes.size() > 0 && bank === notes[0].bank) begin
      nt = notes.pop_front();
      num_checks++;
      if (anode !== nt.anode || lp !== nt.lp || bright !== nt.bright) begin
        errors++;
        $display("[ERR] %0t bank %h anode %h expected %h", $time, bank, anode, nt.anode);
      end
    end
  end
  initial begin
    rstn = 1'b0;
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    expect_scan();
    for (int c = 0; c < 2; c++) begin
      cfg = c ? 8'hA1 : 8'h45;
      load({16'h0000, cfg}, c ? 32 : 8, 8);
      expect_scan();
      for (int i = 0; i < 16; i++) begin
        disp = {1'(rnd()), 3'(i), 4'(i + 4), 4'(i + 3), 4'(i + 2), 4'(i + 1), 4'(i)};
        load(disp, disp_len[i % 5], 24);
        expect_scan();
      end
      cfg = 8'h00;
      load({16'h0000, cfg}, 64, 8);
      expect_scan();
      disp = 24'(rnd());
      load(disp, 24, 24);
      load(24'h00_0000, 20, 0);
    end
    cfg = 8'hA1;
    load({16'h0000, cfg}, 96, 8);
    load({16'h0000, cfg}, 104, 8);
    load(24'h00_0000, 48, 0);
    disp = 24'h8A_5F0C;
    load(disp, 48, 24);
    expect_scan();
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
